// ==== hw/pdps_top.sv ====
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "pdps_regs.svh"
// Contract
// - Alt port enabled activates three alternate pins, same function as legacy pins; device_reset_out never follows the alternate reset level.
// - Legacy reset, clock and data pins stay usable with alt port enabled.
// - High voltage on legacy reset pin makes alternate reset pin ignored.
// - Count-select low: behave as small variant; ports D/E, streaming port, PWM off.
// - Count-select high: full-feature configuration, all peripherals present.
// - Count-select honoured only with debug enabled and alt port enabled.
// - Single-supply bit: program without high voltage; entry pin leaves GPIO.
// - High-voltage programming entry always accepted regardless of single-supply bit; alternate high voltage waits until a single-supply session ends.
// - Single-supply bit changes only in high-voltage mode; clear returns GPIO.
// - With single-supply disabled only high-voltage entry is accepted.
// - Row or block erase when unprotected; protected memory only block erase.
module pdps_top
   import pdps_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   // Avalon-MM register slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Legacy port pins
   input  wire logic        reset_progvolt_hv_in,
   input  wire logic        reset_progvolt_level_in,
   input  wire logic        legacy_serial_clock_in,
   input  wire logic        legacy_serial_data_in,
   output logic             legacy_serial_data_out,
   output logic             legacy_serial_data_oe_out,
   // Alternate port pins
   input  wire logic        alt_reset_progvolt_hv_in,
   input  wire logic        alt_reset_progvolt_level_in,
   input  wire logic        alt_serial_clock_pin_in,
   input  wire logic        alt_serial_data_pin_in,
   output logic             alt_serial_data_pin_out,
   output logic             alt_serial_data_pin_oe_out,
   // Strap and entry pins
   input  wire logic        pin_count_select_pin_in,
   input  wire logic        prog_entry_pin_in,
   // Serial engine side
   input  wire logic        serial_data_drive_in,
   input  wire logic        serial_data_value_in,
   output logic             serial_clock_rise_out,
   output logic             serial_data_bit_out,
   output logic             prog_active_out,
   output logic             device_reset_out,
   output logic             port_b_bit_five_gpio_out,
   // Erase requests towards the memory
   output logic             row_erase_out,
   output logic             block_erase_out,
   // Peripheral presence
   output logic             small_variant_out,
   output logic             port_d_io_enable_out,
   output logic             port_e_io_enable_out,
   output logic             streaming_parallel_port_enable_out,
   output logic             first_capture_compare_pwm_enable_out
);

   // Pin synchroniser stages and their filtered levels
   logic [`PDPS_NUM_PINS-1:0] pin_raw;
   logic [`PDPS_NUM_PINS-1:0] sync_a;
   logic [`PDPS_NUM_PINS-1:0] sync_b;
   logic [`PDPS_NUM_PINS-1:0] sync_c;
   logic [`PDPS_NUM_PINS-1:0] pin_flt;
   pdps_pins_type             pins;
   pdps_cfg_type              cfg;
   pdps_session_type          session;
   pdps_session_type          next_session;
   logic                      clk_prev;
   logic                      erase_error;
   logic                      bus_ack;

   // Raw pin vector in the order the header defines
   assign pin_raw = {prog_entry_pin_in, pin_count_select_pin_in,
                     alt_serial_data_pin_in, alt_serial_clock_pin_in,
                     alt_reset_progvolt_level_in, alt_reset_progvolt_hv_in,
                     legacy_serial_data_in, legacy_serial_clock_in,
                     reset_progvolt_level_in, reset_progvolt_hv_in};

   // Three-flop synchroniser per pin; a change counts once the last two agree
   genvar gi;
   generate
      for (gi = 0; gi < `PDPS_NUM_PINS; gi = gi + 1) begin : g_sync
         always_ff @(posedge clock_in) begin
            if (!rst_n_in) begin
               sync_a[gi]  <= 1'b0;
               sync_b[gi]  <= 1'b0;
               sync_c[gi]  <= 1'b0;
               pin_flt[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
               if (sync_b[gi] == sync_c[gi]) begin
                  pin_flt[gi] <= sync_c[gi];
               end
            end
         end
      end
   endgenerate

   // Alternate pins have no internal effect unless the port is enabled
   wire       alt_on     = cfg.alt_port;
   assign pins = {pin_flt[`PDPS_PIN_PROG_ENTRY], pin_flt[`PDPS_PIN_COUNT_SEL],
                  pin_flt[`PDPS_PIN_ALT_DAT] & alt_on,
                  pin_flt[`PDPS_PIN_ALT_CLK] & alt_on,
                  pin_flt[`PDPS_PIN_ALT_RST] | ~alt_on,
                  pin_flt[`PDPS_PIN_ALT_HV] & alt_on,
                  pin_flt[`PDPS_PIN_LEG_DAT], pin_flt[`PDPS_PIN_LEG_CLK],
                  pin_flt[`PDPS_PIN_LEG_RST], pin_flt[`PDPS_PIN_LEG_HV]};

   // Entry conditions; legacy high voltage wins and masks the alternate reset
   wire leg_hv_entry = pins.leg_hv;
   wire alt_hv_entry = pins.alt_hv & ~pins.leg_hv;
   wire single_entry = cfg.single_sup & pins.leg_rst & pins.prog_entry;

   // Session selection: a session runs until its own entry condition drops or legacy high voltage takes it over
   always_comb begin
      next_session = session;
      case (session)
         PDPS_IDLE: begin
            if (leg_hv_entry) begin
               next_session = PDPS_HV_LEG;
            end else if (alt_hv_entry) begin
               next_session = PDPS_HV_ALT;
            end else if (single_entry) begin
               next_session = PDPS_SINGLE;
            end
         end
         PDPS_HV_LEG: begin
            if (!leg_hv_entry) begin
               next_session = PDPS_IDLE;
            end
         end
         PDPS_HV_ALT: begin
            if (leg_hv_entry) begin
               next_session = PDPS_HV_LEG;
            end else if (!alt_hv_entry) begin
               next_session = PDPS_IDLE;
            end
         end
         PDPS_SINGLE: begin
            if (leg_hv_entry) begin
               next_session = PDPS_HV_LEG;
            end else if (!single_entry) begin
               next_session = PDPS_IDLE;
            end
         end
         default: next_session = PDPS_IDLE;
      endcase
   end

   // Session register
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         session <= PDPS_IDLE;
      end else begin
         session <= next_session;
      end
   end

   // Port steering follows the open session
   wire use_alt    = (session == PDPS_HV_ALT);
   wire prog_on    = (session != PDPS_IDLE);
   wire hv_on      = (session == PDPS_HV_LEG) | use_alt;
   wire sel_clk    = use_alt ? pins.alt_clk : pins.leg_clk;
   wire sel_dat    = use_alt ? pins.alt_dat : pins.leg_dat;
   wire sel_rst    = use_alt ? pins.alt_rst : pins.leg_rst;
   wire clk_rise   = prog_on & sel_clk & ~clk_prev;

   // Serial clock edge detection on the filtered level of the chosen port
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         clk_prev              <= 1'b1;
         serial_clock_rise_out <= 1'b0;
         serial_data_bit_out   <= 1'b0;
      end else begin
         // Held high outside a session: a session that opens with the clock
         // already high, or on the other port, cannot fake an edge
         clk_prev              <= prog_on ? sel_clk : 1'b1;
         serial_clock_rise_out <= clk_rise;
         if (clk_rise) begin
            serial_data_bit_out <= sel_dat;
         end
      end
   end

   // Data driven back only on the port that opened the session
   assign legacy_serial_data_out     = serial_data_value_in;
   assign legacy_serial_data_oe_out  = prog_on & ~use_alt & serial_data_drive_in;
   assign alt_serial_data_pin_out    = serial_data_value_in & alt_on;
   assign alt_serial_data_pin_oe_out = alt_on & use_alt & serial_data_drive_in;
   assign prog_active_out            = prog_on;
   assign device_reset_out           = ~prog_on & ~sel_rst;
   assign port_b_bit_five_gpio_out   = ~cfg.single_sup;

   // Pin-count strap only counts with debug on and the alternate port enabled
   wire strap_live = ~cfg.debug_off & cfg.alt_port;
   wire small_mode = strap_live & ~pins.count_sel;
   // Every larger-package peripheral follows the one strap decision
   assign small_variant_out                    = small_mode;
   assign port_d_io_enable_out                 = ~small_mode;
   assign port_e_io_enable_out                 = ~small_mode;
   assign streaming_parallel_port_enable_out   = ~small_mode;
   assign first_capture_compare_pwm_enable_out = ~small_mode;

   // Bus decode
   // Writes act at the taking edge; the master holds them until the answer
   wire acc_take   = (avs_read_in | avs_write_in) & ~bus_ack;
   wire wr_take    = avs_write_in & ~bus_ack;
   wire hit_cfg    = (avs_address_in == `PDPS_ADDR_CONFIG);
   wire hit_status = (avs_address_in == `PDPS_ADDR_STATUS);
   wire hit_erase  = (avs_address_in == `PDPS_ADDR_ERASE);
   wire wr_cfg     = wr_take & hit_cfg;
   wire wr_status  = wr_take & hit_status;
   wire wr_erase   = wr_take & hit_erase;
   wire row_req    = wr_erase & avs_writedata_in[`PDPS_ER_ROW];
   wire block_req  = wr_erase & avs_writedata_in[`PDPS_ER_BLOCK];
   // Row erase never reaches protected memory; only a block erase clears it
   wire row_ok     = row_req & prog_on & ~cfg.protect & ~block_req;
   wire block_ok   = block_req & prog_on;
   // A refused erase raises the sticky error instead of a pulse
   wire erase_bad  = (row_req & ~row_ok & ~block_req) | (block_req & ~block_ok);
   // Alt-port bit changes only in a legacy high-voltage session
   wire alt_wr_ok  = (session == PDPS_HV_LEG);
   wire sup_wr_ok  = hv_on;

   // Configuration bits; alt-port and single-supply writes guarded; protection only cleared by block erase
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cfg <= pdps_cfg_type'(`PDPS_CFG_RESET);
      end else begin
         if (wr_cfg && alt_wr_ok) begin
            cfg.alt_port <= avs_writedata_in[`PDPS_CFG_ALT_PORT];
         end
         if (wr_cfg && sup_wr_ok) begin
            cfg.single_sup <= avs_writedata_in[`PDPS_CFG_SINGLE_SUP];
         end
         // Debug bit is unguarded; it only matters together with the strap
         if (wr_cfg) begin
            cfg.debug_off <= avs_writedata_in[`PDPS_CFG_DEBUG_OFF];
         end
         if (block_ok) begin
            cfg.protect <= 1'b0;
         end else if (wr_cfg && avs_writedata_in[`PDPS_CFG_PROTECT]) begin
            cfg.protect <= 1'b1;
         end
      end
   end

   // Erase pulses and sticky refusal flag; a new refusal beats a clear
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         row_erase_out   <= 1'b0;
         block_erase_out <= 1'b0;
         erase_error     <= 1'b0;
      end else begin
         row_erase_out   <= row_ok;
         block_erase_out <= block_ok;
         if (erase_bad) begin
            erase_error <= 1'b1;
         end else if (wr_status && avs_writedata_in[`PDPS_ST_ERASE_ERROR]) begin
            erase_error <= 1'b0;
         end
      end
   end

   // Read mux; unmapped addresses read zero
   wire [31:0] cfg_word = {28'h0000000, cfg};
   wire [31:0] st_word  = {26'h0, erase_error, small_mode, use_alt,
                           (session == PDPS_SINGLE), hv_on, prog_on};
   wire [31:0] rd_word  = hit_cfg    ? cfg_word :
                          hit_status ? st_word  : 32'h00000000;

   // One wait cycle per access keeps the read data registered
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         bus_ack          <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         bus_ack <= acc_take;
         if (acc_take && avs_read_in) begin
            avs_readdata_out <= rd_word;
         end
      end
   end

   // Follows the request at once, so a fresh access stalls without a lost cycle
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack;

endmodule // pdps_top

// ==== hw/pdps_regs.svh ====
`ifndef PDPS_REGS_SVH
`define PDPS_REGS_SVH

// Register word offsets (byte addresses)
`define PDPS_ADDR_CONFIG      4'h0
`define PDPS_ADDR_STATUS      4'h4
`define PDPS_ADDR_ERASE       4'h8

// Configuration register fields
`define PDPS_CFG_ALT_PORT     0
`define PDPS_CFG_DEBUG_OFF    1
`define PDPS_CFG_SINGLE_SUP   2
`define PDPS_CFG_PROTECT      3
`define PDPS_CFG_RESET        4'h6

// Status register fields
`define PDPS_ST_PROG_ACTIVE   0
`define PDPS_ST_HIGH_VOLT     1
`define PDPS_ST_SINGLE_ENTRY  2
`define PDPS_ST_ALT_SESSION   3
`define PDPS_ST_SMALL_VARIANT 4
`define PDPS_ST_ERASE_ERROR   5

// Erase command fields
`define PDPS_ER_ROW           0
`define PDPS_ER_BLOCK         1

// Synchronised pin vector positions
`define PDPS_PIN_LEG_HV       0
`define PDPS_PIN_LEG_RST      1
`define PDPS_PIN_LEG_CLK      2
`define PDPS_PIN_LEG_DAT      3
`define PDPS_PIN_ALT_HV       4
`define PDPS_PIN_ALT_RST      5
`define PDPS_PIN_ALT_CLK      6
`define PDPS_PIN_ALT_DAT      7
`define PDPS_PIN_COUNT_SEL    8
`define PDPS_PIN_PROG_ENTRY   9
`define PDPS_NUM_PINS         10
`define PDPS_PIN_RESET        10'h000

`endif

// ==== hw/pdps_pkg.sv ====
package pdps_pkg;

   // Synchronised external pin levels
   typedef struct packed {
      logic prog_entry;
      logic count_sel;
      logic alt_dat;
      logic alt_clk;
      logic alt_rst;
      logic alt_hv;
      logic leg_dat;
      logic leg_clk;
      logic leg_rst;
      logic leg_hv;
   } pdps_pins_type;

   // Configuration bits held by the block
   typedef struct packed {
      logic protect;
      logic single_sup;
      logic debug_off;
      logic alt_port;
   } pdps_cfg_type;

   // Programming session selection
   typedef enum logic [3:0] {
      PDPS_IDLE     = 4'b0001,
      PDPS_HV_LEG   = 4'b0010,
      PDPS_HV_ALT   = 4'b0100,
      PDPS_SINGLE   = 4'b1000
   } pdps_session_type;

endpackage

// ==== tb/pdps_top_sva.sv ====
`timescale 1ns/1ns
module pdps_sva_checker (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       avs_read_in,
   input wire logic       avs_write_in,
   input wire logic [3:0] avs_address_in,
   input wire logic       avs_waitrequest_out,
   input wire logic       reset_progvolt_hv_in,
   input wire logic       prog_active_out,
   input wire logic       serial_clock_rise_out,
   input wire logic       alt_serial_data_pin_oe_out,
   input wire logic       row_erase_out,
   input wire logic       block_erase_out,
   input wire logic       port_b_bit_five_gpio_out,
   input wire logic       small_variant_out,
   input wire logic       port_d_io_enable_out,
   input wire logic       port_e_io_enable_out,
   input wire logic       streaming_parallel_port_enable_out,
   input wire logic       first_capture_compare_pwm_enable_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // A pending access is answered in the following cycle
   property p_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait) else $error("access not answered after one cycle");
   // Held high voltage always opens a session, whatever the configuration
   property p_hv; reset_progvolt_hv_in [*8] |-> prog_active_out; endproperty
   a_hv: assert property (p_hv) else $error("high voltage entry refused");
   // Link edges are far apart, so each pulse stands alone
   property p_rise; serial_clock_rise_out |=> !serial_clock_rise_out [*5]; endproperty
   a_rise: assert property (p_rise) else $error("serial edge pulse too long");
   // The alternate data pin is driven only inside a session
   property p_altoe; alt_serial_data_pin_oe_out |-> prog_active_out; endproperty
   a_altoe: assert property (p_altoe) else $error("alternate data driven idle");
   property p_small; small_variant_out |-> !port_d_io_enable_out && !port_e_io_enable_out
      && !streaming_parallel_port_enable_out && !first_capture_compare_pwm_enable_out;
   endproperty
   a_small: assert property (p_small) else $error("large peripheral left on");
   property p_full; !small_variant_out |-> port_d_io_enable_out && port_e_io_enable_out
      && streaming_parallel_port_enable_out && first_capture_compare_pwm_enable_out;
   endproperty
   a_full: assert property (p_full) else $error("peripheral missing in full mode");
   property p_row; row_erase_out |-> !block_erase_out && $past(prog_active_out); endproperty
   a_row: assert property (p_row) else $error("row erase outside session");
   property p_blk; block_erase_out |-> $past(avs_write_in) && $past(prog_active_out)
      && ($past(avs_address_in) == 4'h8);
   endproperty
   a_blk: assert property (p_blk) else $error("block erase without command");
   // The entry pin returns to general use only by a change made in session
   property p_gpio; $changed(port_b_bit_five_gpio_out) |-> $past(prog_active_out); endproperty
   a_gpio: assert property (p_gpio) else $error("entry pin use changed idle");
   c_small: cover property (small_variant_out);
   c_row: cover property (row_erase_out);
   c_blk: cover property (block_erase_out);
   c_altoe: cover property (alt_serial_data_pin_oe_out);
endmodule // pdps_sva_checker
bind pdps_top pdps_sva_checker u_sva (.clock_in, .rst_n_in, .avs_read_in, .avs_write_in,
   .avs_address_in, .avs_waitrequest_out, .reset_progvolt_hv_in, .prog_active_out,
   .serial_clock_rise_out, .alt_serial_data_pin_oe_out, .row_erase_out, .block_erase_out,
   .port_b_bit_five_gpio_out, .small_variant_out, .port_d_io_enable_out,
   .port_e_io_enable_out, .streaming_parallel_port_enable_out,
   .first_capture_compare_pwm_enable_out);

// ==== tb/pdps_tool_model.sv ====
`timescale 1ns/1ns
module pdps_tool_model (
   input  wire logic [1:0] mode_in,
   input  wire logic       leg_oe_in,
   input  wire logic       leg_dev_in,
   input  wire logic       alt_oe_in,
   input  wire logic       alt_dev_in,
   output logic            hv_out,
   output logic            rst_level_out,
   output logic            leg_clk_out,
   output logic            leg_dat_out,
   output logic            alt_hv_out,
   output logic            alt_rst_level_out,
   output logic            alt_clk_out,
   output logic            alt_dat_out,
   output logic            entry_out
);
   logic sclk = 1'b0;
   logic sdat = 1'b0;
   // Serial clock at 125 ns, parked low between sessions
   always begin
      #63 sclk = (mode_in != 2'd0) ? ~sclk : 1'b0;
      #62 sclk = (mode_in != 2'd0) ? ~sclk : 1'b0;
   end
   // New bit on every falling clock, so a stale level never looks valid
   always @(negedge sclk) sdat = ~sdat;
   // Mode 1 legacy high voltage, 2 alternate high voltage, 3 entry pin
   assign hv_out = (mode_in == 2'd1);
   assign alt_hv_out = (mode_in == 2'd2);
   assign rst_level_out = 1'b1;
   // Entry pin driven hard at both levels, so no pull-up can ever raise it
   assign entry_out = (mode_in == 2'd3);
   // Alternate reset sinks low under legacy high voltage, a hostile level to ignore
   assign alt_rst_level_out = (mode_in != 2'd1);
   assign leg_clk_out = (mode_in == 2'd2) ? 1'b0 : sclk;
   // Only the full package is modelled, where the alternate port may be enabled
   assign alt_clk_out = (mode_in == 2'd2) ? sclk : 1'b0;
   // Device drive wins on the data wire
   assign leg_dat_out = leg_oe_in ? leg_dev_in : sdat;
   assign alt_dat_out = alt_oe_in ? alt_dev_in : ~sdat;
endmodule // pdps_tool_model

// ==== tb/tb_programming_debug_port_select.sv ====
`timescale 1ns/1ns
module tb_programming_debug_port_select;
   logic clock_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [3:0] avs_address_in = 4'h0;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd, seed = 32'ha2ae;
   logic avs_waitrequest_out, reset_progvolt_hv_in, reset_progvolt_level_in, w;
   logic legacy_serial_clock_in, legacy_serial_data_in, legacy_serial_data_out;
   logic legacy_serial_data_oe_out, alt_reset_progvolt_hv_in, alt_reset_progvolt_level_in;
   logic alt_serial_clock_pin_in, alt_serial_data_pin_in, alt_serial_data_pin_out;
   logic alt_serial_data_pin_oe_out, pin_count_select_pin_in = 1'b1, prog_entry_pin_in;
   logic serial_data_drive_in = 1'b0, serial_data_value_in = 1'b0, serial_clock_rise_out;
   logic serial_data_bit_out, prog_active_out, device_reset_out, port_b_bit_five_gpio_out;
   logic row_erase_out, block_erase_out, small_variant_out, port_d_io_enable_out;
   logic port_e_io_enable_out, streaming_parallel_port_enable_out;
   logic first_capture_compare_pwm_enable_out;
   logic [1:0] mode = 2'd0, er;
   logic [2:0] v;
   int fails = 0, total_checks = 0, cycles = 0;
   pdps_top u_dut (.clock_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .reset_progvolt_hv_in,
      .reset_progvolt_level_in, .legacy_serial_clock_in, .legacy_serial_data_in,
      .legacy_serial_data_out, .legacy_serial_data_oe_out, .alt_reset_progvolt_hv_in,
      .alt_reset_progvolt_level_in, .alt_serial_clock_pin_in, .alt_serial_data_pin_in,
      .alt_serial_data_pin_out, .alt_serial_data_pin_oe_out, .pin_count_select_pin_in,
      .prog_entry_pin_in, .serial_data_drive_in, .serial_data_value_in,
      .serial_clock_rise_out, .serial_data_bit_out, .prog_active_out, .device_reset_out,
      .port_b_bit_five_gpio_out, .row_erase_out, .block_erase_out, .small_variant_out,
      .port_d_io_enable_out, .port_e_io_enable_out, .streaming_parallel_port_enable_out,
      .first_capture_compare_pwm_enable_out);
   pdps_tool_model u_tool (.mode_in(mode), .leg_oe_in(legacy_serial_data_oe_out),
      .leg_dev_in(legacy_serial_data_out), .alt_oe_in(alt_serial_data_pin_oe_out),
      .alt_dev_in(alt_serial_data_pin_out), .hv_out(reset_progvolt_hv_in),
      .rst_level_out(reset_progvolt_level_in), .leg_clk_out(legacy_serial_clock_in),
      .leg_dat_out(legacy_serial_data_in), .alt_hv_out(alt_reset_progvolt_hv_in),
      .alt_rst_level_out(alt_reset_progvolt_level_in), .alt_clk_out(alt_serial_clock_pin_in),
      .alt_dat_out(alt_serial_data_pin_in), .entry_out(prog_entry_pin_in));
   always #5 clock_in = ~clock_in;
   // Engine drive pattern cycles so both data directions are exercised
   always @(posedge clock_in) begin
      {serial_data_drive_in, serial_data_value_in} <= {serial_data_value_in, ~serial_data_drive_in};
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         close_out();
      end
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Small variant only with debug on, alternate port on and strap low
   function automatic logic exp_small(input logic [2:0] c);
      return c[0] & ~c[1] & ~c[2];
   endfunction
   task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
      total_checks = total_checks + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("unexpected at %0t: want %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_pin(input logic e, input logic g);
      total_checks = total_checks + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("unexpected at %0t: want %h got %h", $time, e, g);
      end
   endtask
   // One bus access from a rising edge; everything is sampled at rising edges,
   // and an erase pulse from the taking edge still stands at the completing one
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      er = 2'b00;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= ~wr;
      avs_write_in <= wr;
      do begin
         @(posedge clock_in);
         w = avs_waitrequest_out;
         er = er | {block_erase_out, row_erase_out};
      end while (w !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task automatic go(input logic [1:0] m);
      mode <= m;
      repeat (10) @(posedge clock_in);
   endtask
   // Returns mid-cycle, while the edge pulse stands
   task automatic wait_rise();
      int n;
      n = 0;
      do begin
         @(negedge clock_in);
         n++;
      end while (serial_clock_rise_out !== 1'b1 && n < 100);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      bus(1'b0, 4'hc, 32'h0);
      chk_word(32'h0, rd);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      chk_word(32'h4, rd);
      chk_pin(1'b0, port_b_bit_five_gpio_out);
      go(2'd1);
      bus(1'b0, 4'h4, 32'h0);
      chk_word(32'h3, rd);
      bus(1'b1, 4'h0, 32'h1);
      chk_pin(1'b1, port_b_bit_five_gpio_out);
      chk_pin(1'b0, device_reset_out);
      wait_rise();
      chk_pin(1'b1, serial_clock_rise_out);
      chk_pin(serial_data_drive_in, legacy_serial_data_oe_out);
      chk_pin(serial_data_value_in, legacy_serial_data_out);
      chk_pin(1'b0, alt_serial_data_pin_oe_out);
      bus(1'b1, 4'h8, 32'h1);
      chk_word(32'h1, {30'h0, er});
      bus(1'b1, 4'h0, 32'h9);
      bus(1'b1, 4'h8, 32'h1);
      chk_word(32'h0, {30'h0, er});
      bus(1'b0, 4'h4, 32'h0);
      chk_word(32'h23, rd);
      bus(1'b1, 4'h8, 32'h2);
      chk_word(32'h2, {30'h0, er});
      bus(1'b0, 4'h0, 32'h0);
      chk_word(32'h1, rd);
      bus(1'b1, 4'h4, 32'h20);
      // Every strap, debug and port combination, then random ones
      for (int i = 0; i < 12; i++) begin
         seed = next_rand(seed);
         v = (i < 8) ? i[2:0] : seed[2:0];
         bus(1'b1, 4'h0, {30'h0, v[1:0]});
         pin_count_select_pin_in <= v[2];
         repeat (6) @(posedge clock_in);
         chk_pin(exp_small(v), small_variant_out);
         chk_pin(~exp_small(v), port_d_io_enable_out);
         if (!v[0]) begin
            chk_pin(1'b0, alt_serial_data_pin_oe_out);
            chk_pin(1'b0, alt_serial_data_pin_out);
         end
      end
      pin_count_select_pin_in <= 1'b1;
      bus(1'b1, 4'h0, 32'h5);
      go(2'd2);
      bus(1'b0, 4'h4, 32'h0);
      chk_word(32'h9, rd & 32'h9);
      wait_rise();
      chk_pin(1'b1, serial_clock_rise_out);
      chk_pin(serial_data_drive_in, alt_serial_data_pin_oe_out);
      chk_pin(serial_data_value_in, alt_serial_data_pin_out);
      chk_pin(1'b0, legacy_serial_data_oe_out);
      go(2'd3);
      bus(1'b0, 4'h4, 32'h0);
      chk_word(32'h5, rd & 32'h5);
      go(2'd1);
      bus(1'b1, 4'h0, 32'h1);
      go(2'd3);
      bus(1'b0, 4'h4, 32'h0);
      chk_word(32'h0, rd & 32'h1);
      go(2'd0);
      close_out();
   end
endmodule // tb_programming_debug_port_select
